// ### core/flash_programmer_mode_port.sv
// Programmer-mode command sequencer for the on-chip flash array
`timescale 1ns/10ps
`default_nettype none
// Overview of operation
// - Writing 00 at any address enters memory read; reads return stored bytes.
// - Writing 40 then 128 address/data writes programs one block: 129 cycles.
// - Writing 20 twice in consecutive writes starts auto-erase.
// - Writing 71 twice in consecutive writes enters status read.
// - Finished operations fall to command wait; read needs a new 00 command.
// - Memory read mode accepts command writes exactly like command wait.
// - Memory read serves unlimited back-to-back reads without new commands.
// - After reset the port starts in memory read mode.
// - Block address low 7 bits must be zero; otherwise write proceeds, error flagged.
// - Done bit marks completion; end-result bit or status read confirms success.
// - Polling bits hold until next command other than 71; driven when chip select and gate low.
// - Auto-erase always clears the whole array.
// - No commands during erase; end-result bit confirms normal erase.
// - Auto-program completes within 1 to 3000 ms.
// - Auto-erase completes within 100 to 40000 ms.
// - Read data is valid within 20 us of the address.
// - Write: CE low, OE high, WE low; read: CE, OE low; CE high floats.
// - Done and end-result read 0 while busy, both 1 on normal end.
module flash_programmer_mode_port #(
  parameter int PROG_MIN_CYC = flash_prog_pkg::PROG_MIN_CYC,
  parameter int PROG_MAX_CYC = flash_prog_pkg::PROG_MAX_CYC,
  parameter int ERASE_MIN_CYC = flash_prog_pkg::ERASE_MIN_CYC,
  parameter int ERASE_MAX_CYC = flash_prog_pkg::ERASE_MAX_CYC
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Programmer pins
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic program_permit,
  input wire logic [flash_prog_pkg::ADDR_W-1:0] addr,
  input wire logic [flash_prog_pkg::DATA_W-1:0] data_in,
  output logic [flash_prog_pkg::DATA_W-1:0] data_out,
  output logic data_oe,
  // Array read port, one cycle latency
  output logic [flash_prog_pkg::ADDR_W-1:0] read_location,
  input wire logic [flash_prog_pkg::DATA_W-1:0] array_rd_data,
  // Array write and operation port
  output logic array_wr_en,
  output logic [flash_prog_pkg::ADDR_W-1:0] array_wr_addr,
  output logic [flash_prog_pkg::DATA_W-1:0] array_wr_data,
  output logic program_active,
  output logic erase_active,
  input wire logic array_done,
  // Polling flags as levels
  output logic done_flag,
  output logic end_result_flag
);

  localparam logic [flash_prog_pkg::TIMER_W-1:0] PMIN =
    flash_prog_pkg::TIMER_W'(PROG_MIN_CYC - 1);
  localparam logic [flash_prog_pkg::TIMER_W-1:0] PMAX =
    flash_prog_pkg::TIMER_W'(PROG_MAX_CYC - 1);
  localparam logic [flash_prog_pkg::TIMER_W-1:0] EMIN =
    flash_prog_pkg::TIMER_W'(ERASE_MIN_CYC - 1);
  localparam logic [flash_prog_pkg::TIMER_W-1:0] EMAX =
    flash_prog_pkg::TIMER_W'(ERASE_MAX_CYC - 1);
  localparam logic [flash_prog_pkg::BLOCK_LSB_W-1:0] LAST_IDX =
    flash_prog_pkg::BLOCK_LSB_W'(flash_prog_pkg::BLOCK_BYTES - 1);

  flash_prog_pkg::pins_type raw_pins;
  flash_prog_pkg::pins_type pins;
  flash_prog_pkg::pins_type pins_prev;
  flash_prog_pkg::state_type state;
  logic write_stb;
  logic read_sel;
  logic [7:0] cmd_byte;
  logic [flash_prog_pkg::BLOCK_LSB_W-1:0] load_idx;
  logic [flash_prog_pkg::ADDR_W-1:0] block_location;
  logic addr_error;
  logic [7:0] block_buf [flash_prog_pkg::BLOCK_BYTES];
  logic [flash_prog_pkg::TIMER_W-1:0] timer;
  logic done_seen;
  logic finish_ok;
  logic finish_bad;
  logic busy;

  // True where any command may be written
  function automatic logic cmd_state(input flash_prog_pkg::state_type s);
    return s == flash_prog_pkg::S_READ || s == flash_prog_pkg::S_CMD_WAIT ||
           s == flash_prog_pkg::S_STATUS;
  endfunction : cmd_state

  assign raw_pins = '{ce_n: ce_n, oe_n: oe_n, we_n: we_n, program_permit: program_permit,
                      addr: addr, data: data_in};

  // Pins come from the programmer's clock-free world
  pin_sync #(
    .WIDTH(flash_prog_pkg::PINS_W)
  ) u_sync (
    .core_clk(core_clk),
    .srst(srst),
    .d(raw_pins),
    .q(pins)
  );

  // One sample of history to find the end of the write pulse
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pins_prev <= '1;
    end else begin
      pins_prev <= pins;
    end
  end

  // Data is taken on the strobe's rising edge, where setup is met
  assign write_stb = !pins_prev.we_n && pins.we_n && !pins_prev.ce_n && pins_prev.oe_n;
  assign read_sel = !pins.ce_n && !pins.oe_n && pins.we_n;
  assign cmd_byte = pins_prev.data;
  assign busy = state == flash_prog_pkg::S_PROG_BUSY || state == flash_prog_pkg::S_ERASE_BUSY;

  // Finish decisions, respecting the least and longest operation times
  always_comb begin
    finish_ok = 1'b0;
    finish_bad = 1'b0;
    if (state == flash_prog_pkg::S_PROG_BUSY) begin
      finish_ok = (timer >= PMIN) && (done_seen || array_done);
      finish_bad = !finish_ok && timer >= PMAX;
    end else if (state == flash_prog_pkg::S_ERASE_BUSY) begin
      finish_ok = (timer >= EMIN) && (done_seen || array_done);
      finish_bad = !finish_ok && timer >= EMAX;
    end
  end

  // Command sequencer
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state <= flash_prog_pkg::S_READ;
    end else begin
      unique case (state)
        flash_prog_pkg::S_READ, flash_prog_pkg::S_CMD_WAIT, flash_prog_pkg::S_STATUS: begin
          if (write_stb) begin
            if (cmd_byte == flash_prog_pkg::CMD_READ) begin
              state <= flash_prog_pkg::S_READ;
            end else if (cmd_byte == flash_prog_pkg::CMD_PROGRAM && pins_prev.program_permit) begin
              state <= flash_prog_pkg::S_PROG_LOAD;
            end else if (cmd_byte == flash_prog_pkg::CMD_ERASE && pins_prev.program_permit) begin
              state <= flash_prog_pkg::S_ERASE_ARM;
            end else if (cmd_byte == flash_prog_pkg::CMD_STATUS) begin
              state <= flash_prog_pkg::S_STATUS_ARM;
            end else begin
              state <= flash_prog_pkg::S_CMD_WAIT;
            end
          end
        end
        flash_prog_pkg::S_PROG_LOAD: begin
          if (write_stb && load_idx == LAST_IDX) begin
            state <= flash_prog_pkg::S_PROG_WRITE;
          end
        end
        flash_prog_pkg::S_PROG_WRITE: begin
          if (load_idx == LAST_IDX) begin
            state <= flash_prog_pkg::S_PROG_BUSY;
          end
        end
        flash_prog_pkg::S_ERASE_ARM: begin
          if (write_stb) begin
            state <= (cmd_byte == flash_prog_pkg::CMD_ERASE) ? flash_prog_pkg::S_ERASE_BUSY
                                                             : flash_prog_pkg::S_CMD_WAIT;
          end
        end
        flash_prog_pkg::S_STATUS_ARM: begin
          if (write_stb) begin
            state <= (cmd_byte == flash_prog_pkg::CMD_STATUS) ? flash_prog_pkg::S_STATUS
                                                              : flash_prog_pkg::S_CMD_WAIT;
          end
        end
        flash_prog_pkg::S_PROG_BUSY, flash_prog_pkg::S_ERASE_BUSY: begin
          // Writes here are ignored; the programmer must not send any
          if (finish_ok || finish_bad) begin
            state <= flash_prog_pkg::S_CMD_WAIT;
          end
        end
        default: begin
          state <= flash_prog_pkg::S_CMD_WAIT;
        end
      endcase
    end
  end

  // Block loading: first data write carries the block address
  always_ff @(posedge core_clk) begin
    if (srst) begin
      load_idx <= '0;
      block_location <= '0;
      addr_error <= 1'b0;
    end else if (state == flash_prog_pkg::S_PROG_LOAD && write_stb) begin
      if (load_idx == '0) begin
        block_location <= pins_prev.addr;
        addr_error <= |pins_prev.addr[flash_prog_pkg::BLOCK_LSB_W-1:0];
      end
      load_idx <= load_idx + 1'b1;
    end else if (state == flash_prog_pkg::S_PROG_WRITE) begin
      load_idx <= load_idx + 1'b1;
    end else if (cmd_state(state)) begin
      load_idx <= '0;
    end
  end

  // Page buffer; the array takes the block one byte per cycle
  always_ff @(posedge core_clk) begin
    if (state == flash_prog_pkg::S_PROG_LOAD && write_stb) begin
      block_buf[load_idx] <= cmd_byte;
    end
  end

  // Stream the block; a bad address still writes, with low bits forced clear
  always_ff @(posedge core_clk) begin
    if (srst) begin
      array_wr_en <= 1'b0;
      array_wr_addr <= '0;
      array_wr_data <= '0;
    end else begin
      array_wr_en <= state == flash_prog_pkg::S_PROG_WRITE;
      array_wr_addr <= {block_location[flash_prog_pkg::ADDR_W-1:flash_prog_pkg::BLOCK_LSB_W],
                        load_idx};
      array_wr_data <= block_buf[load_idx];
    end
  end

  // Operation requests as levels; erase covers the whole array
  always_ff @(posedge core_clk) begin
    if (srst) begin
      program_active <= 1'b0;
      erase_active <= 1'b0;
    end else begin
      program_active <= state == flash_prog_pkg::S_PROG_BUSY && !(finish_ok || finish_bad);
      erase_active <= state == flash_prog_pkg::S_ERASE_BUSY && !(finish_ok || finish_bad);
    end
  end

  // Operation timer and early-completion memory
  always_ff @(posedge core_clk) begin
    if (srst) begin
      timer <= '0;
      done_seen <= 1'b0;
    end else if (busy) begin
      timer <= timer + 1'b1;
      done_seen <= done_seen || array_done;
    end else begin
      timer <= '0;
      done_seen <= 1'b0;
    end
  end

  // Polling flags: cleared by any write but a 71 outside busy, held until then; finish wins
  always_ff @(posedge core_clk) begin
    if (srst) begin
      done_flag <= 1'b0;
      end_result_flag <= 1'b0;
    end else if (finish_ok || finish_bad) begin
      done_flag <= 1'b1;
      end_result_flag <= finish_ok && !(state == flash_prog_pkg::S_PROG_BUSY && addr_error);
    end else if (write_stb && !busy && cmd_byte != flash_prog_pkg::CMD_STATUS) begin
      done_flag <= 1'b0;
      end_result_flag <= 1'b0;
    end
  end

  // Read path: address sampled, array answers a cycle later
  always_ff @(posedge core_clk) begin
    if (srst) begin
      read_location <= '0;
    end else begin
      read_location <= pins.addr;
    end
  end

  // Output byte and drive enable; chip select high floats the bus
  always_ff @(posedge core_clk) begin
    if (srst) begin
      data_out <= '0;
      data_oe <= 1'b0;
    end else begin
      data_oe <= read_sel;
      if (state == flash_prog_pkg::S_READ) begin
        data_out <= array_rd_data;
      end else begin
        data_out <= {done_flag, end_result_flag, flash_prog_pkg::POLL_LOW_ZERO};
      end
    end
  end

  // Checks
  property p_read_cmd;
    @(posedge core_clk) disable iff (srst)
      cmd_state(state) && write_stb && cmd_byte == flash_prog_pkg::CMD_READ
      |=> state == flash_prog_pkg::S_READ;
  endproperty
  a_read_cmd: assert property (p_read_cmd) else $error("read command not taken");

  sequence s_last_byte;
    state == flash_prog_pkg::S_PROG_LOAD && write_stb && load_idx == LAST_IDX;
  endsequence
  property p_block_load;
    @(posedge core_clk) disable iff (srst)
      s_last_byte |=> state == flash_prog_pkg::S_PROG_WRITE ##1
      (state == flash_prog_pkg::S_PROG_WRITE && array_wr_en);
  endproperty
  a_block_load: assert property (p_block_load) else $error("block not streamed");

  sequence s_erase_pair;
    state == flash_prog_pkg::S_ERASE_ARM && write_stb && cmd_byte == flash_prog_pkg::CMD_ERASE;
  endsequence
  property p_erase_start;
    @(posedge core_clk) disable iff (srst)
      s_erase_pair |=> state == flash_prog_pkg::S_ERASE_BUSY ##1 erase_active;
  endproperty
  a_erase_start: assert property (p_erase_start) else $error("erase did not start");

  property p_status_pair;
    @(posedge core_clk) disable iff (srst)
      state == flash_prog_pkg::S_STATUS_ARM && write_stb && cmd_byte != flash_prog_pkg::CMD_STATUS
      |=> state == flash_prog_pkg::S_CMD_WAIT;
  endproperty
  a_status_pair: assert property (p_status_pair) else $error("bad status pair accepted");

  property p_finish_wait;
    @(posedge core_clk) disable iff (srst)
      busy && (finish_ok || finish_bad) |=> state == flash_prog_pkg::S_CMD_WAIT && done_flag;
  endproperty
  a_finish_wait: assert property (p_finish_wait) else $error("no command wait after op");

  property p_reset_read;
    @(posedge core_clk) srst |=> state == flash_prog_pkg::S_READ;
  endproperty
  a_reset_read: assert property (p_reset_read) else $error("not in read after reset");

  property p_busy_flags;
    @(posedge core_clk) disable iff (srst)
      $rose(busy) |-> !done_flag && !end_result_flag;
  endproperty
  a_busy_flags: assert property (p_busy_flags) else $error("flags set while busy");

  property p_addr_err;
    @(posedge core_clk) disable iff (srst)
      state == flash_prog_pkg::S_PROG_BUSY && finish_ok && addr_error
      |=> done_flag && !end_result_flag;
  endproperty
  a_addr_err: assert property (p_addr_err) else $error("address error not flagged");

  property p_erase_min;
    @(posedge core_clk) disable iff (srst)
      state == flash_prog_pkg::S_ERASE_BUSY && timer < EMIN |=> state == flash_prog_pkg::S_ERASE_BUSY;
  endproperty
  a_erase_min: assert property (p_erase_min) else $error("erase ended too early");

  property p_prog_max;
    @(posedge core_clk) disable iff (srst)
      state == flash_prog_pkg::S_PROG_BUSY && timer >= PMAX && !done_seen && !array_done
      |=> state == flash_prog_pkg::S_CMD_WAIT && !end_result_flag;
  endproperty
  a_prog_max: assert property (p_prog_max) else $error("program timeout missed");

  property p_read_data;
    @(posedge core_clk) disable iff (srst)
      state == flash_prog_pkg::S_READ ##1 state == flash_prog_pkg::S_READ
      |-> data_out == $past(array_rd_data);
  endproperty
  a_read_data: assert property (p_read_data) else $error("read data wrong");

  property p_poll_drive;
    @(posedge core_clk) disable iff (srst)
      read_sel && state == flash_prog_pkg::S_CMD_WAIT && $stable(done_flag)
      |=> data_oe && data_out[flash_prog_pkg::DONE_BIT] == $past(done_flag) &&
          data_out[flash_prog_pkg::RESULT_BIT] == $past(end_result_flag);
  endproperty
  a_poll_drive: assert property (p_poll_drive) else $error("polling bits not driven");

endmodule : flash_programmer_mode_port
`default_nettype wire

// ### core/pin_sync.sv
// Two-flop synchroniser for the programmer pin bundle
`timescale 1ns/10ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1,
  parameter logic [WIDTH-1:0] IDLE = '1
) (
  // Clock and reset
  input wire logic core_clk,
  input wire logic srst,
  // Asynchronous pins in, synchronised copy out
  input wire logic [WIDTH-1:0] d,
  output logic [WIDTH-1:0] q
);

  logic [WIDTH-1:0] meta;

  // First stage feeds only the second; idle level under reset
  always_ff @(posedge core_clk) begin
    if (srst) begin
      meta <= IDLE;
      q <= IDLE;
    end else begin
      meta <= d;
      q <= meta;
    end
  end

endmodule : pin_sync
`default_nettype wire

// ### dv/flash_array_model.sv
// Behavioural flash array that answers the sequencer's array ports
`timescale 1ns/10ps
`default_nettype none
module flash_array_model (
  // Clock
  input wire logic core_clk,
  // Read port
  input wire logic [flash_prog_pkg::ADDR_W-1:0] read_location,
  output logic [7:0] array_rd_data,
  // Write and operation port
  input wire logic array_wr_en,
  input wire logic [flash_prog_pkg::ADDR_W-1:0] array_wr_addr,
  input wire logic [7:0] array_wr_data,
  input wire logic program_active,
  input wire logic erase_active,
  output logic array_done,
  // Busy cycles before done is reported; large values force a timeout
  input wire logic [31:0] done_after
);
  logic [7:0] mem [int];
  bit erased = 1'b0;
  int busy = 0;
  initial array_rd_data = 8'h00;
  initial array_done = 1'b0;
  // One-cycle read; unwritten bytes show a seed pattern until erased
  always @(posedge core_clk) begin
    if (mem.exists(int'(read_location))) array_rd_data <= mem[int'(read_location)];
    else array_rd_data <= erased ? 8'hFF : (read_location[7:0] ^ 8'hA5);
    if (array_wr_en) mem[int'(array_wr_addr)] = array_wr_data;
  end
  // Done level after the set delay; stays low while idle
  always @(posedge core_clk) begin
    busy = (program_active | erase_active) ? busy + 1 : 0;
    array_done <= (busy != 0) && (busy >= done_after);
    if (erase_active && busy == done_after) begin
      mem.delete();
      erased = 1'b1;
    end
  end
endmodule : flash_array_model
`default_nettype wire

// ### dv/test_flash_programmer_mode_port.sv
// Self-checking bench for the programmer-mode flash port
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, b) begin num_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("mismatch at %0t: got %h expected %h", $time, (a), (b)); end end
module test_flash_programmer_mode_port;
  localparam int AW = flash_prog_pkg::ADDR_W;
  localparam int PMIN = 20;
  localparam int PMAX = 200;
  localparam int EMIN = 30;
  localparam int EMAX = 300;
  localparam int GAP = 200;  // Command spacing of 20 us at 10 MHz
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic permit = 1'b1;
  flash_prog_pkg::pins_type pins;
  logic [7:0] data_out, array_rd_data, array_wr_data;
  logic [AW-1:0] read_location, array_wr_addr, a, base;
  logic data_oe, array_wr_en, program_active, erase_active, array_done;
  logic done_flag, end_result_flag;
  logic [31:0] done_after = 32'h5;
  int fail_count = 0;
  int num_checks = 0;
  int wr_cnt = 0;
  int busy_cnt = 0;
  int blk, b0;
  bit erased = 1'b0;
  logic [7:0] exp_mem [int];
  always #50 core_clk = ~core_clk;
  // Running counts of array strobes and busy cycles, read as differences
  always @(posedge core_clk) begin
    wr_cnt <= wr_cnt + int'(array_wr_en);
    busy_cnt <= busy_cnt + int'(program_active | erase_active);
  end
  flash_programmer_mode_port #(.PROG_MIN_CYC(PMIN), .PROG_MAX_CYC(PMAX),
    .ERASE_MIN_CYC(EMIN), .ERASE_MAX_CYC(EMAX)) dut_u (
    .core_clk(core_clk), .srst(srst), .ce_n(pins.ce_n), .oe_n(pins.oe_n),
    .we_n(pins.we_n), .program_permit(pins.program_permit), .addr(pins.addr),
    .data_in(pins.data), .data_out(data_out), .data_oe(data_oe),
    .read_location(read_location), .array_rd_data(array_rd_data),
    .array_wr_en(array_wr_en), .array_wr_addr(array_wr_addr),
    .array_wr_data(array_wr_data), .program_active(program_active),
    .erase_active(erase_active), .array_done(array_done),
    .done_flag(done_flag), .end_result_flag(end_result_flag));
  flash_array_model array_u (
    .core_clk(core_clk), .read_location(read_location), .array_rd_data(array_rd_data),
    .array_wr_en(array_wr_en), .array_wr_addr(array_wr_addr),
    .array_wr_data(array_wr_data), .program_active(program_active),
    .erase_active(erase_active), .array_done(array_done), .done_after(done_after));
  // Reference contents: written bytes, else seed pattern or erased level
  function automatic logic [7:0] expv(input int x);
    if (exp_mem.exists(x)) return exp_mem[x];
    return erased ? 8'hFF : (x[7:0] ^ 8'hA5);
  endfunction : expv
  task automatic test_done();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : test_done
  // One write cycle; strobe held well past the two-flop pin sync
  task automatic wr(input logic [AW-1:0] ad, input logic [7:0] d, input int gap);
    @(posedge core_clk);
    pins <= '{ce_n:1'b0, oe_n:1'b1, we_n:1'b0, program_permit:permit, addr:ad, data:d};
    repeat (4) @(posedge core_clk);
    pins.we_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    pins.ce_n <= 1'b1;
    repeat (gap) @(posedge core_clk);
  endtask : wr
  // One read cycle; checks the byte, then that the bus is let go
  task automatic rd(input logic [AW-1:0] ad, input logic [7:0] e);
    @(posedge core_clk);
    pins <= '{ce_n:1'b0, oe_n:1'b0, we_n:1'b1, program_permit:permit, addr:ad, data:8'h00};
    repeat (8) @(posedge core_clk);
    #1;
    `CHK(data_oe, 1'b1)
    `CHK(data_out, e)
    @(posedge core_clk);
    pins.ce_n <= 1'b1;
    pins.oe_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    #1;
    `CHK(data_oe, 1'b0)
  endtask : rd
  // Bounded wait for the done polling bit
  task automatic wait_done(input int bound);
    int n;
    n = 0;
    while (done_flag !== 1'b1 && n < bound) begin
      @(negedge core_clk);
      n++;
    end
    if (n >= bound) begin
      `CHK(done_flag, 1'b1)
      test_done();
    end
  endtask : wait_done
  // Full block program; low bits give a misaligned block address
  task automatic prog(input int bk, input logic [6:0] low, input logic [7:0] poll);
    int w0;
    logic [7:0] d;
    base = {bk[10:0], 7'h00};
    w0 = wr_cnt;
    b0 = busy_cnt;
    wr('0, flash_prog_pkg::CMD_PROGRAM, GAP);
    for (int i = 0; i < 128; i++) begin
      d = ($urandom % 4 == 0) ? flash_prog_pkg::FILL_BYTE : 8'($urandom);
      exp_mem[int'(base) + i] = d;
      wr((i == 0) ? (base | {11'h000, low}) : ~base, d, 2);
    end
    rd(base, 8'h00);
    repeat (PMIN) @(posedge core_clk);
    wait_done(PMAX + 400);
    `CHK(wr_cnt - w0, 128)
    `CHK((busy_cnt - b0) inside {[PMIN - 1 : PMAX + 1]}, 1'b1)
    `CHK({done_flag, end_result_flag}, poll[7:6])
    rd(base, poll);
    repeat (50) @(posedge core_clk);
    rd(~base, poll);
  endtask : prog
  initial begin
    void'($urandom(98042));
    pins = '{ce_n:1'b1, oe_n:1'b1, we_n:1'b1, program_permit:1'b1, addr:'0, data:8'h00};
    repeat (2) @(posedge core_clk);
    srst <= 1'b0;
    for (int i = 0; i < 4; i++) begin
      a = AW'($urandom);
      rd(a, expv(int'(a)));
    end
    $display("test power-on read done");
    permit = 1'b0;
    b0 = busy_cnt;
    wr('0, flash_prog_pkg::CMD_ERASE, GAP);
    wr('0, flash_prog_pkg::CMD_ERASE, GAP);
    `CHK(busy_cnt - b0, 0)
    permit = 1'b1;
    wr(AW'($urandom), flash_prog_pkg::CMD_READ, GAP);
    a = AW'($urandom);
    rd(a, expv(int'(a)));
    $display("test refused erase done");
    b0 = busy_cnt;
    wr('0, flash_prog_pkg::CMD_ERASE, GAP);
    wr(AW'($urandom), flash_prog_pkg::CMD_ERASE, 2);
    erased = 1'b1;
    exp_mem.delete();
    wait_done(EMAX + 50);
    `CHK((busy_cnt - b0) inside {[EMIN - 1 : EMAX + 1]}, 1'b1)
    rd('0, 8'hC0);
    wr('0, flash_prog_pkg::CMD_READ, GAP);
    for (int i = 0; i < 4; i++) rd(AW'($urandom), 8'hFF);
    $display("test erase done");
    blk = $urandom_range(0, 1000);
    prog(blk, 7'h00, 8'hC0);
    wr('0, flash_prog_pkg::CMD_STATUS, GAP);
    wr('0, flash_prog_pkg::CMD_STATUS, GAP);
    rd('0, 8'hC0);
    wr('0, flash_prog_pkg::CMD_READ, GAP);
    for (int i = 0; i < 128; i++) rd(base + AW'(i), expv(int'(base) + i));
    wr('0, flash_prog_pkg::CMD_STATUS, GAP);
    wr('0, flash_prog_pkg::CMD_STATUS, GAP);
    rd('0, 8'h00);
    $display("test program done");
    prog(blk + 3, 7'h15, 8'h80);
    wr('0, flash_prog_pkg::CMD_READ, GAP);
    for (int i = 0; i < 4; i++) rd(base + AW'(i), expv(int'(base) + i));
    $display("test misaligned program done");
    done_after = 32'h0000FFFF;
    prog(blk + 6, 7'h00, 8'h80);
    $display("test program timeout done");
    test_done();
  end
endmodule : test_flash_programmer_mode_port
`default_nettype wire

// ### inc/flash_prog_pkg.sv
// Constants, state codes and pin bundle for the programmer-mode flash port
package flash_prog_pkg;

  // Clock and derived rates
  localparam int CLK_HZ = 10_000_000;
  localparam int CYCLES_PER_MS = CLK_HZ / 1000;
  localparam int CYCLES_PER_US = CLK_HZ / 1_000_000;

  // Operation time windows, in their printed units
  localparam int PROG_MIN_MS = 1;
  localparam int PROG_MAX_MS = 3000;
  localparam int ERASE_MIN_MS = 100;
  localparam int ERASE_MAX_MS = 40000;
  localparam int ACCESS_MAX_US = 20;

  // Cycle counts: least and longest times both round down with the truncated rates
  localparam int PROG_MIN_CYC = PROG_MIN_MS * CYCLES_PER_MS;
  localparam int PROG_MAX_CYC = PROG_MAX_MS * CYCLES_PER_MS;
  localparam int ERASE_MIN_CYC = ERASE_MIN_MS * CYCLES_PER_MS;
  localparam int ERASE_MAX_CYC = ERASE_MAX_MS * CYCLES_PER_MS;
  localparam int ACCESS_MAX_CYC = ACCESS_MAX_US * CYCLES_PER_US;
  localparam int TIMER_W = 29;

  // Bus geometry
  localparam int ADDR_W = 18;
  localparam int DATA_W = 8;
  localparam int BLOCK_BYTES = 128;
  localparam int BLOCK_LSB_W = 7;

  // Command codes
  localparam logic [7:0] CMD_READ = 8'h00;
  localparam logic [7:0] CMD_PROGRAM = 8'h40;
  localparam logic [7:0] CMD_ERASE = 8'h20;
  localparam logic [7:0] CMD_STATUS = 8'h71;
  localparam logic [7:0] FILL_BYTE = 8'hFF;

  // Polling byte layout
  localparam int DONE_BIT = 7;
  localparam int RESULT_BIT = 6;
  localparam logic [5:0] POLL_LOW_ZERO = 6'h00;

  // Sequencer states, Gray along the program and erase paths out of command wait
  typedef enum logic [3:0] {
    S_READ = 4'h0,
    S_CMD_WAIT = 4'h1,
    S_PROG_LOAD = 4'h3,
    S_PROG_WRITE = 4'h2,
    S_PROG_BUSY = 4'h6,
    S_ERASE_ARM = 4'h5,
    S_ERASE_BUSY = 4'h4,
    S_STATUS_ARM = 4'hC,
    S_STATUS = 4'hD
  } state_type;

  // Programmer-side pin bundle, sampled together
  typedef struct packed {
    logic ce_n;
    logic oe_n;
    logic we_n;
    logic program_permit;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
  } pins_type;

  localparam int PINS_W = $bits(pins_type);

endpackage : flash_prog_pkg
